// ===== core/ubm_pkg.sv
package ubm_pkg;

    // Register offsets of the break matcher, byte addresses on Wishbone
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
    localparam logic [7:0] OFS_MASK_HIGH = 8'h08;
    localparam logic [7:0] OFS_MASK_LOW  = 8'h0C;
    localparam logic [7:0] OFS_CYC_SEL   = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // Register offsets of the interrupt controller end
    localparam logic [7:0] OFS_LEVEL     = 8'h00;
    localparam logic [7:0] OFS_CSTAT     = 8'h04;

    // Field positions inside break_cycle_select
    localparam int SEL_SRC_LO  = 6;
    localparam int SEL_FD_LO   = 4;
    localparam int SEL_DIR_LO  = 2;
    localparam int SEL_SIZE_LO = 0;

    // Select codes; in a pair bit 0 picks the first kind, bit 1 the second; the size field is a plain code
    localparam logic [1:0] SEL_NONE  = 2'h0;
    localparam logic [1:0] SIZE_ANY  = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LONG = 2'h3;

    // Reset values
    localparam logic [15:0] RST_HALF  = 16'h0000;
    localparam logic [7:0]  RST_SEL   = 8'h00;
    localparam logic [3:0]  RST_LEVEL = 4'hF;

    // Priority of the user break and the highest mask level
    localparam logic [3:0] BREAK_PRIO = 4'hF;
    localparam logic [3:0] LEVEL_TOP  = 4'hF;

    // Byte distance between the two instructions of a paired fetch
    localparam logic [31:0] INST_STEP = 32'h00000002;

    typedef enum logic [3:0] {
        DST_IDLE  = 4'h1,
        DST_ARMED = 4'h2,
        DST_DEFER = 4'h4,
        DST_REQ   = 4'h8
    } ubm_dstate_t;

    typedef enum logic [2:0] {
        CST_IDLE = 3'h1,
        CST_WAIT = 3'h2,
        CST_TAKE = 3'h4
    } ubm_cstate_t;

endpackage : ubm_pkg

// ===== core/ubm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ubm_link_if;
    logic        brk_req;
    logic [31:0] brk_pc;
    logic        brk_odd;
    logic        brk_ack;

    modport dev (
        output brk_req,
        output brk_pc,
        output brk_odd,
        input  brk_ack
    );

    modport ctl (
        input  brk_req,
        input  brk_pc,
        input  brk_odd,
        output brk_ack
    );
endinterface : ubm_link_if
`default_nettype wire

// ===== core/ubm_matcher.sv
// Operation
// - Any source, fetch/data or direction pair at 00 blocks breaks.
// - Full match raises user break request.
// - Controller accepts priority 15 at level <=14.
// - Masked request stays pending, never dropped.
// - NMI sets mask level to 15.
// - Paired fetch matches each instruction separately.
// - Fetch break precedes instruction; saves break address.
// - Non-interruptible match defers to next instruction.
// - Data break saves next-instruction address.
// - Fetch with write-only never breaks.
// - Odd fetch match flagged behind address error.
// - Word data break at odd address never fires.
// - DMA with fetch-only never breaks.
// - Select encoding decodes to fixed cycle kinds.
// - Address is high half above low half.
// - Paired second match survives register rewrite.
// - Taken branch overrun-fetches two, executes target.
// - Controller forwards accepted break to processor.
// - Set mask bit excludes address bit.
// - Pairs: 01 first, 10 second, 11 both.
// - Size field 00 any, byte, word, long.
// - Overrun fetch match breaks there immediately.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ubm_matcher (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Observed bus cycle
    input  wire logic        cyc_done_i,
    input  wire logic [31:0] cyc_addr_i,
    input  wire logic        cyc_dma_i,
    input  wire logic        cyc_fetch_i,
    input  wire logic        cyc_write_i,
    input  wire logic [1:0]  cyc_size_i,
    input  wire logic        cyc_pair_i,
    input  wire logic        cyc_overrun_i,
    // Processor execution
    input  wire logic        exec_start_i,
    input  wire logic [31:0] exec_addr_i,
    input  wire logic        exec_irq_ok_i,
    input  wire logic [31:0] exec_next_pc_i,
    // Link to the interrupt controller
    ubm_link_if.dev          link
);

    typedef struct packed {
        logic [15:0]         addr_hi;
        logic [15:0]         addr_lo;
        logic [15:0]         mask_hi;
        logic [15:0]         mask_lo;
        logic [7:0]          cyc_sel;
        logic                ack;
        logic [31:0]         rdata;
        ubm_pkg::ubm_dstate_t st;
        logic [31:0]         arm_addr;
        logic                req;
        logic [31:0]         pc;
        logic                odd;
    } ubm_mstate_t;

    ubm_mstate_t s;
    ubm_mstate_t next_s;

    logic [31:0] brk_addr;
    logic [31:0] brk_mask;
    logic [1:0]  sel_src;
    logic [1:0]  sel_fd;
    logic [1:0]  sel_dir;
    logic [1:0]  sel_size;
    logic [1:0]  eff_size;
    logic        kind_ok;
    logic        data_odd;
    logic [31:0] slot_addr [2];
    logic [1:0]  slot_hit;
    logic [31:0] hit_addr;

    assign brk_addr = {s.addr_hi, s.addr_lo};
    assign brk_mask = {s.mask_hi, s.mask_lo};
    assign sel_src  = s.cyc_sel[ubm_pkg::SEL_SRC_LO +: 2];
    assign sel_fd   = s.cyc_sel[ubm_pkg::SEL_FD_LO +: 2];
    assign sel_dir  = s.cyc_sel[ubm_pkg::SEL_DIR_LO +: 2];
    assign sel_size = s.cyc_sel[ubm_pkg::SEL_SIZE_LO +: 2];

    // Fetches count as word accesses whatever the bus width
    assign eff_size = cyc_fetch_i ? ubm_pkg::SIZE_WORD : cyc_size_i;

    // A 00 source, fetch/data or direction pair has neither bit set and so never passes
    assign kind_ok = (cyc_dma_i   ? sel_src[1] : sel_src[0])
                   & (cyc_fetch_i ? sel_fd[0]  : sel_fd[1])
                   & (cyc_write_i ? sel_dir[1] : sel_dir[0])
                   & ((sel_size == ubm_pkg::SIZE_ANY) | (sel_size == eff_size));

    // Word data never sits at an odd address, so such a cycle cannot match
    assign data_odd = ~cyc_fetch_i & (cyc_size_i == ubm_pkg::SIZE_WORD)
                    & cyc_addr_i[0];

    // Slot 1 is the second instruction of a 32-bit on-chip fetch
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_slot
            assign slot_addr[gi] = (gi == 0) ? cyc_addr_i
                                 : cyc_addr_i + ubm_pkg::INST_STEP;
            assign slot_hit[gi] = cyc_done_i & kind_ok & ~data_odd
                & (((slot_addr[gi] ^ brk_addr) & ~brk_mask) == 32'h00000000)
                & ((gi == 0) | (cyc_fetch_i & cyc_pair_i));
        end
    endgenerate

    assign hit_addr = slot_hit[0] ? slot_addr[0] : slot_addr[1];

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    always_comb begin
        next_s     = s;
        next_s.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack   = 1'b1;
            next_s.rdata = 32'h00000000;
            case (wb_adr_i)
                ubm_pkg::OFS_ADDR_HIGH: begin
                    next_s.rdata[15:0] = s.addr_hi;
                    if (wb_we_i) begin
                        next_s.addr_hi = merge16(s.addr_hi, wb_dat_i, wb_sel_i);
                    end
                end
                ubm_pkg::OFS_ADDR_LOW: begin
                    next_s.rdata[15:0] = s.addr_lo;
                    if (wb_we_i) begin
                        next_s.addr_lo = merge16(s.addr_lo, wb_dat_i, wb_sel_i);
                    end
                end
                ubm_pkg::OFS_MASK_HIGH: begin
                    next_s.rdata[15:0] = s.mask_hi;
                    if (wb_we_i) begin
                        next_s.mask_hi = merge16(s.mask_hi, wb_dat_i, wb_sel_i);
                    end
                end
                ubm_pkg::OFS_MASK_LOW: begin
                    next_s.rdata[15:0] = s.mask_lo;
                    if (wb_we_i) begin
                        next_s.mask_lo = merge16(s.mask_lo, wb_dat_i, wb_sel_i);
                    end
                end
                ubm_pkg::OFS_CYC_SEL: begin
                    // Bits 15..8 are reserved and read as zero
                    next_s.rdata[7:0] = s.cyc_sel;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_s.cyc_sel = wb_dat_i[7:0];
                    end
                end
                ubm_pkg::OFS_STATUS: begin
                    next_s.rdata[3:0] = s.st;
                    next_s.rdata[4]   = s.req;
                end
                default: begin
                    next_s.rdata = 32'h00000000;
                end
            endcase
        end

        case (s.st)
            ubm_pkg::DST_IDLE: begin
                if (slot_hit[0] && !cyc_fetch_i) begin
                    next_s.req = 1'b1;
                    next_s.pc  = exec_next_pc_i;
                    next_s.odd = 1'b0;
                    next_s.st  = ubm_pkg::DST_REQ;
                end else if (slot_hit != 2'h0 && cyc_overrun_i) begin
                    // Overrun instructions never execute, so break now
                    next_s.req = 1'b1;
                    next_s.pc  = hit_addr;
                    next_s.odd = hit_addr[0];
                    next_s.st  = ubm_pkg::DST_REQ;
                end else if (slot_hit != 2'h0) begin
                    // Address is kept so a later rewrite cannot cancel it
                    next_s.arm_addr = hit_addr;
                    next_s.odd      = hit_addr[0];
                    next_s.st       = ubm_pkg::DST_ARMED;
                end
            end
            ubm_pkg::DST_ARMED: begin
                if (exec_start_i && exec_addr_i == s.arm_addr) begin
                    if (exec_irq_ok_i) begin
                        next_s.req = 1'b1;
                        next_s.pc  = s.arm_addr;
                        next_s.st  = ubm_pkg::DST_REQ;
                    end else begin
                        next_s.st  = ubm_pkg::DST_DEFER;
                    end
                end
            end
            ubm_pkg::DST_DEFER: begin
                if (exec_start_i && exec_irq_ok_i) begin
                    next_s.req = 1'b1;
                    next_s.pc  = exec_addr_i;
                    next_s.st  = ubm_pkg::DST_REQ;
                end
            end
            ubm_pkg::DST_REQ: begin
                // Request holds until the controller takes it
                if (link.brk_ack) begin
                    next_s.req = 1'b0;
                    next_s.st  = ubm_pkg::DST_IDLE;
                end
            end
            default: begin
                next_s.req = 1'b0;
                next_s.st  = ubm_pkg::DST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s.addr_hi  <= ubm_pkg::RST_HALF;
            s.addr_lo  <= ubm_pkg::RST_HALF;
            s.mask_hi  <= ubm_pkg::RST_HALF;
            s.mask_lo  <= ubm_pkg::RST_HALF;
            s.cyc_sel  <= ubm_pkg::RST_SEL;
            s.ack      <= 1'b0;
            s.rdata    <= 32'h00000000;
            s.st       <= ubm_pkg::DST_IDLE;
            s.arm_addr <= 32'h00000000;
            s.req      <= 1'b0;
            s.pc       <= 32'h00000000;
            s.odd      <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o     = s.rdata;
    assign wb_ack_o     = s.ack;
    assign link.brk_req = s.req;
    assign link.brk_pc  = s.pc;
    assign link.brk_odd = s.odd;

endmodule : ubm_matcher
`default_nettype wire

// ===== core/ubm_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module ubm_interrupt_controller (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Processor side
    input  wire logic        nmi_i,
    output logic             brk_take_o,
    output logic      [31:0] brk_pc_o,
    output logic             brk_odd_o,
    output logic      [3:0]  mask_level_o,
    // Link to the break matcher
    ubm_link_if.ctl          link
);

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic [3:0]           level;
        ubm_pkg::ubm_cstate_t st;
        logic                 take;
        logic [31:0]          pc;
        logic                 odd;
    } ubm_cstate_reg_t;

    ubm_cstate_reg_t s;
    ubm_cstate_reg_t next_s;
    logic            accept;

    // Only a strictly lower mask level lets priority 15 through
    assign accept = link.brk_req && (s.level < ubm_pkg::BREAK_PRIO);

    always_comb begin
        next_s      = s;
        next_s.ack  = 1'b0;
        next_s.take = 1'b0;
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack   = 1'b1;
            next_s.rdata = 32'h00000000;
            case (wb_adr_i)
                ubm_pkg::OFS_LEVEL: begin
                    next_s.rdata[3:0] = s.level;
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_s.level = wb_dat_i[3:0];
                    end
                end
                ubm_pkg::OFS_CSTAT: begin
                    next_s.rdata[2:0] = s.st;
                    next_s.rdata[3]   = link.brk_req;
                end
                default: begin
                    next_s.rdata = 32'h00000000;
                end
            endcase
        end

        case (s.st)
            ubm_pkg::CST_IDLE: begin
                if (accept) begin
                    next_s.st = ubm_pkg::CST_TAKE;
                end else if (link.brk_req) begin
                    next_s.st = ubm_pkg::CST_WAIT;
                end
            end
            ubm_pkg::CST_WAIT: begin
                if (accept) begin
                    next_s.st = ubm_pkg::CST_TAKE;
                end
            end
            ubm_pkg::CST_TAKE: begin
                // Exception entry raises the mask, like any level-15 source
                next_s.take  = 1'b1;
                next_s.pc    = link.brk_pc;
                next_s.odd   = link.brk_odd;
                next_s.level = ubm_pkg::LEVEL_TOP;
                next_s.st    = ubm_pkg::CST_IDLE;
            end
            default: begin
                next_s.st = ubm_pkg::CST_IDLE;
            end
        endcase

        // Hardware raise wins over a software write in the same cycle
        if (nmi_i) begin
            next_s.level = ubm_pkg::LEVEL_TOP;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s.ack   <= 1'b0;
            s.rdata <= 32'h00000000;
            s.level <= ubm_pkg::RST_LEVEL;
            s.st    <= ubm_pkg::CST_IDLE;
            s.take  <= 1'b0;
            s.pc    <= 32'h00000000;
            s.odd   <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o     = s.rdata;
    assign wb_ack_o     = s.ack;
    assign brk_take_o   = s.take;
    assign brk_pc_o     = s.pc;
    assign brk_odd_o    = s.odd;
    assign mask_level_o = s.level;
    assign link.brk_ack = s.st == ubm_pkg::CST_TAKE;

endmodule : ubm_interrupt_controller
`default_nettype wire

// ===== dv/ubm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ubm_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // Link between the two ends
    input wire logic        brk_req,
    input wire logic [31:0] brk_pc,
    input wire logic        brk_odd,
    input wire logic        brk_ack
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_ack_after_req; brk_ack |-> $past(brk_req); endproperty
    a_ack_after_req: assert property (p_ack_after_req)
        else $error("accept without a pending request");
    property p_ack_pulse; brk_ack |=> !brk_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("accept longer than one cycle");
    property p_req_clears; brk_ack |=> !brk_req; endproperty
    a_req_clears: assert property (p_req_clears)
        else $error("request still up after accept");
    property p_req_pending; brk_req && !brk_ack |=> brk_req; endproperty
    a_req_pending: assert property (p_req_pending)
        else $error("request dropped before accept");
    property p_pc_steady; brk_req && !brk_ack |=> $stable(brk_pc); endproperty
    a_pc_steady: assert property (p_pc_steady)
        else $error("saved pc moved while pending");
    property p_odd_steady;
        brk_req && !brk_ack |=> $stable(brk_odd);
    endproperty
    a_odd_steady: assert property (p_odd_steady)
        else $error("odd flag moved while pending");
    property p_ack_with_req; brk_ack |-> brk_req; endproperty
    a_ack_with_req: assert property (p_ack_with_req)
        else $error("accept seen with no request");
    property p_rise_clean; $rose(brk_req) |-> !brk_ack; endproperty
    a_rise_clean: assert property (p_rise_clean)
        else $error("new request accepted at once");

    c_taken: cover property (brk_ack);
    c_pending: cover property (brk_req [*8]);
    c_odd: cover property (brk_req && brk_odd);
endmodule : ubm_chk
`default_nettype wire

// ===== dv/user_break_matcher_tb.sv
`timescale 1ns/1ps
`default_nettype none
module user_break_matcher_tb;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        cyc_m = 1'b0;
    logic        cyc_c = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd_m, rd_c, tpc;
    logic        ack_m, ack_c, take, odd;
    logic [3:0]  lvl;
    logic        done = 1'b0;
    logic        xs = 1'b0;
    logic        xok = 1'b0;
    logic        nmi = 1'b0;
    logic [6:0]  kind = 7'h00;
    logic [31:0] ca = 32'h0;
    logic [31:0] xa = 32'h0;
    logic [31:0] xn = 32'h0;
    logic [31:0] nxt = 32'h0;
    integer      seed = 88889;
    int          miscompares = 0;
    int          tests_run = 0;
    logic [32:0] q[$];
    // Data cases: select code, {dma,fetch,write,size,pair,overrun}, hit
    logic [15:0] dt[9] = '{16'h6A31, 16'hA799, 16'h2A30, 16'h4A30, 16'h6230,
                           16'h6A10, 16'h6AB0, 16'h6A28, 16'hFCA9};
    logic [8:0]  ft[5] = '{9'h0A9, 9'h0B0, 9'h128, 9'h0AD, 9'h0AE};
    localparam logic [31:0] FA = 32'h00000404;
    ubm_link_if link ();

    ubm_matcher i_ubm_matcher (.clk_i(clk_i), .nrst_i(nrst_i),
        .wb_cyc_i(cyc_m), .wb_stb_i(cyc_m), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_m), .wb_ack_o(ack_m),
        .cyc_done_i(done), .cyc_addr_i(ca), .cyc_dma_i(kind[6]),
        .cyc_fetch_i(kind[5]), .cyc_write_i(kind[4]), .cyc_size_i(kind[3:2]),
        .cyc_pair_i(kind[1]), .cyc_overrun_i(kind[0]), .exec_start_i(xs),
        .exec_addr_i(xa), .exec_irq_ok_i(xok), .exec_next_pc_i(xn),
        .link(link));
    ubm_interrupt_controller i_ubm_interrupt_controller (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc_c),
        .wb_stb_i(cyc_c), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rd_c), .wb_ack_o(ack_c), .nmi_i(nmi),
        .brk_take_o(take), .brk_pc_o(tpc), .brk_odd_o(odd),
        .mask_level_o(lvl), .link(link));
    ubm_chk i_ubm_chk (.clk_i(clk_i), .nrst_i(nrst_i),
        .brk_req(link.brk_req), .brk_pc(link.brk_pc),
        .brk_odd(link.brk_odd), .brk_ack(link.brk_ack));

    always #20 clk_i = ~clk_i;

    task automatic results;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    task automatic fail(input string m);
        miscompares++;
        $display("FAIL %0t %s", $time, m);
    endtask : fail

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) fail("register value");
    endtask : chk_reg

    task automatic chk_brk(input logic [32:0] g, input logic [32:0] e);
        tests_run++;
        if (g !== e) fail("break pc or odd flag");
    endtask : chk_brk

    // One classic cycle; c picks the controller end
    task automatic wb(input bit c, input bit w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r);
        int n;
        n = 0;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        if (c) cyc_c <= 1'b1;
        else cyc_m <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(c ? ack_c : ack_m) && n < 20);
        r = c ? rd_c : rd_m;
        if (n >= 20) begin
            fail("bus answer missing");
            results();
        end
        cyc_m <= 1'b0;
        cyc_c <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Program a condition and open the mask so a break can be taken
    task automatic arm(input logic [31:0] a, input logic [31:0] m,
                       input logic [7:0] s);
        logic [31:0] r;
        wb(0, 1, ubm_pkg::OFS_ADDR_HIGH, {16'h0, a[31:16]}, 4'hF, r);
        wb(0, 1, ubm_pkg::OFS_ADDR_LOW, {16'h0, a[15:0]}, 4'hF, r);
        wb(0, 1, ubm_pkg::OFS_MASK_HIGH, {16'h0, m[31:16]}, 4'hF, r);
        wb(0, 1, ubm_pkg::OFS_MASK_LOW, {16'h0, m[15:0]}, 4'hF, r);
        wb(0, 1, ubm_pkg::OFS_CYC_SEL, {24'h0, s}, 4'hF, r);
        wb(1, 1, ubm_pkg::OFS_LEVEL, 32'h0, 4'hF, r);
    endtask : arm

    task automatic bc(input logic [31:0] a, input logic [6:0] k);
        ca <= a;
        kind <= k;
        xn <= nxt;
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
        @(posedge clk_i);
    endtask : bc

    task automatic ex(input logic [31:0] a, input logic ok);
        xa <= a;
        xok <= ok;
        xs <= 1'b1;
        @(posedge clk_i);
        xs <= 1'b0;
        @(posedge clk_i);
    endtask : ex

    // A break that never shows is only caught if we linger a while
    task automatic settle(input string m);
        int n;
        n = 0;
        while (q.size() != 0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 60) begin
            fail("expected break missing");
            results();
        end
        repeat (12) @(posedge clk_i);
        $display("test %s done", m);
    endtask : settle

    always @(posedge clk_i) begin
        if (take === 1'b1) begin
            if (q.size() == 0) fail("unexpected break taken");
            else chk_brk({odd, tpc}, q.pop_front());
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        fail("run limit reached");
        results();
    end

    initial begin
        logic [31:0] r, a;
        repeat (21) @(posedge clk_i);
        wb(0, 0, ubm_pkg::OFS_STATUS, 32'h0, 4'hF, r);
        chk_reg(r, 32'h00000001);
        wb(1, 0, ubm_pkg::OFS_LEVEL, 32'h0, 4'hF, r);
        chk_reg(r, {28'h0, ubm_pkg::RST_LEVEL});
        wb(0, 1, ubm_pkg::OFS_CYC_SEL, 32'hFFFFFFFF, 4'hE, r);
        wb(0, 0, ubm_pkg::OFS_CYC_SEL, 32'h0, 4'hF, r);
        chk_reg(r, {24'h0, ubm_pkg::RST_SEL});
        wb(0, 1, ubm_pkg::OFS_CYC_SEL, 32'hFFFFFFFF, 4'hF, r);
        wb(0, 0, ubm_pkg::OFS_CYC_SEL, 32'h0, 4'hF, r);
        chk_reg(r, 32'h000000FF);
        wb(0, 0, 8'h3C, 32'h0, 4'hF, r);
        chk_reg(r, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            a = $random(seed) & 32'hFFFFFFFE;
            nxt = $random(seed);
            arm(a, 32'h0, dt[i][15:8]);
            if (dt[i][0]) q.push_back({1'b0, nxt});
            bc(a, dt[i][7:1]);
            settle("data select");
        end
        arm(a | 32'h1, 32'h0, 8'h66);
        bc(a | 32'h1, 7'h08);
        settle("odd word");
        arm(a, 32'h000000F0, 8'hFC);
        bc(a ^ 32'h00000100, 7'h18);
        arm(a, 32'h000000F0, 8'hFC);
        q.push_back({1'b0, nxt});
        bc(a ^ 32'h00000050, 7'h18);
        settle("address mask");
        for (int i = 0; i < 5; i++) begin
            arm(FA, 32'h0, ft[i][8:1]);
            if (ft[i][0]) q.push_back({1'b0, FA});
            bc(FA, 7'h20);
            ex(FA - 32'h2, 1'b1);
            ex(FA, 1'b1);
            settle("fetch select");
        end
        arm(FA, 32'h0, 8'h54);
        q.push_back({1'b0, FA + 32'h2});
        bc(FA, 7'h20);
        ex(FA, 1'b0);
        ex(FA + 32'h2, 1'b1);
        settle("deferred fetch");
        arm(FA + 32'h2, 32'h0, 8'h54);
        q.push_back({1'b0, FA + 32'h2});
        bc(FA, 7'h22);
        arm(32'h00001000, 32'h0, 8'h54);
        ex(FA, 1'b1);
        ex(FA + 32'h2, 1'b1);
        settle("paired fetch");
        arm(FA + 32'h4, 32'h0, 8'h54);
        q.push_back({1'b0, FA + 32'h4});
        bc(FA, 7'h20);
        bc(FA + 32'h2, 7'h21);
        bc(FA + 32'h4, 7'h21);
        settle("overrun fetch");
        arm(32'h00030147, 32'h0, 8'h54);
        q.push_back({1'b1, 32'h00030147});
        bc(32'h00030147, 7'h20);
        ex(32'h00030147, 1'b1);
        settle("odd fetch");
        arm(a, 32'h0, 8'h6A);
        nmi <= 1'b1;
        @(posedge clk_i);
        nmi <= 1'b0;
        @(posedge clk_i);
        chk_reg({28'h0, lvl}, {28'h0, ubm_pkg::LEVEL_TOP});
        bc(a, 7'h18);
        repeat (20) @(posedge clk_i);
        chk_reg({31'h0, link.brk_req}, 32'h1);
        wb(1, 0, ubm_pkg::OFS_CSTAT, 32'h0, 4'hF, r);
        chk_reg(r, 32'h0000000A);
        wb(0, 0, ubm_pkg::OFS_STATUS, 32'h0, 4'hF, r);
        chk_reg(r, 32'h00000018);
        q.push_back({1'b0, nxt});
        wb(1, 1, ubm_pkg::OFS_LEVEL, 32'hE, 4'hF, r);
        settle("mask level");
        results();
    end
endmodule : user_break_matcher_tb
`default_nettype wire
